// ==== hdl/prog_port_pkg.sv ====
// constants and types shared by the parallel programming port
//
// What this block does
// - load pin rising edge: action 00 address, 01 data, 10 command, 11 nothing
// - write or drive strobe low performs the operation of the last command
// - decode erase, fuse, lock, flash, eeprom, signature, fuse read, flash/eeprom reads
// - progress output low while erasing or programming, high when ready
// - first pick selects low/high byte, second pick low/second high byte
// - data bus driven only while drive strobe is low, otherwise input
// - page latch pulse moves loaded data into flash or eeprom page buffer
// - removing the high voltage on reset leaves programming mode
// - command and address stay loaded across many operations
// - erase clears flash, eeprom, then lock bits; fuses untouched
// - eeprom kept through erase when the keep fuse is programmed
// - erase: load command 1000 0000, pulse write, device busy until done
// - flash written a whole page at once, page of 64 words by default
// - eeprom written a whole page at once, page of 4 bytes by default
// - write pulse after filling programs the page, progress low until done
// - loading command 0000 0000 ends page programming, clears write state
package prog_port_pkg;
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;

    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;

    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [7:0] NO_DATA = 8'h00;
    localparam logic [7:0] FUSE_LOW_RESET = 8'h62;
    localparam logic [7:0] FUSE_HIGH_RESET = 8'hd9;
    localparam logic [7:0] FUSE_EXT_RESET = 8'hff;
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam int KEEP_EE_BIT = 3;
    localparam logic [3:0] ENTRY_PATTERN = 4'h0;

    localparam int FLASH_PAGE_WORDS = 64;
    localparam int EE_PAGE_BYTES = 4;
    localparam int PROG_CYCLES = 16;
    localparam int ERASE_CYCLES = 32;

    typedef struct packed {
        logic hv;
        logic load;
        logic [1:0] action;
        logic pick_first;
        logic pick_second;
        logic page_latch;
        logic write_n;
        logic drive_n;
        logic [7:0] data;
    } pin_group_t;

    localparam pin_group_t IDLE_PINS = pin_group_t'(17'h0_0300);

    typedef enum {ST_IDLE, ST_BUSY, ST_LOCK_CLEAR} op_state_t;
endpackage

// ==== hdl/pin_sync.sv ====
// two flip-flop synchroniser for the programming pins
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            stage <= d;
            q <= stage;
        end
    end
endmodule

// ==== hdl/parallel_program_port.sv ====
// parallel programming port: pin decode, command engine, page buffers, memories
`timescale 1ns/1ns
module parallel_program_port import prog_port_pkg::*; #(
    parameter int FLASH_ADDR_BITS = 13,
    parameter int FLASH_PAGE = FLASH_PAGE_WORDS,
    parameter int EE_ADDR_BITS = 9,
    parameter int EE_PAGE = EE_PAGE_BYTES,
    parameter int PROG_TIME = PROG_CYCLES,
    parameter int ERASE_TIME = ERASE_CYCLES,
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h01, // arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h02, // arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_high_voltage,
    input wire logic load_strobe_pin,
    input wire logic strobe_action_msb,
    input wire logic strobe_action_lsb,
    input wire logic byte_pick_first,
    input wire logic byte_pick_second,
    input wire logic page_latch_strobe,
    input wire logic write_strobe_n,
    input wire logic drive_strobe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic progress_indicator,
    output logic prog_mode
);
    localparam int FLASH_WORDS = 1 << FLASH_ADDR_BITS;
    localparam int EE_BYTES = 1 << EE_ADDR_BITS;
    localparam int FPB = $clog2(FLASH_PAGE);
    localparam int EPB = $clog2(EE_PAGE);

    pin_group_t raw;
    pin_group_t pins;
    pin_group_t last;
    op_state_t state;
    op_state_t next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] cmd, addr_lo, addr_hi, data_lo, data_hi;
    logic [7:0] next_cmd, next_addr_lo, next_addr_hi, next_data_lo, next_data_hi;
    logic [7:0] fuse_low, fuse_high, fuse_ext, lock;
    logic [7:0] next_fuse_low, next_fuse_high, next_fuse_ext, next_lock;
    logic next_prog_mode, next_data_oe, next_progress;
    logic [7:0] next_data_out;
    logic [7:0] rd;

    logic [15:0] flash [FLASH_WORDS];
    logic [15:0] flash_page [FLASH_PAGE];
    logic [7:0] eeprom [EE_BYTES];
    logic [7:0] ee_page [EE_PAGE];

    logic load_rise, latch_rise, write_fall, hv_rise, hv_fall;
    logic accept, page_load, commit, nop_load, keep_eeprom_fuse;
    logic [15:0] full_addr;
    logic [FLASH_ADDR_BITS-1:0] fa;
    logic [EE_ADDR_BITS-1:0] ea;

    function automatic logic is_write_cmd(input logic [7:0] c);
        return c == CMD_ERASE || c == CMD_WR_FUSE || c == CMD_WR_LOCK ||
            c == CMD_WR_FLASH || c == CMD_WR_EE;
    endfunction

    function automatic logic [7:0] sig_byte(input logic [1:0] sel);
        unique case (sel)
            2'h0: return SIG_BYTE0;
            2'h1: return SIG_BYTE1;
            2'h2: return SIG_BYTE2;
            default: return NO_DATA;
        endcase
    endfunction

    assign raw = {reset_high_voltage, load_strobe_pin, strobe_action_msb, strobe_action_lsb,
        byte_pick_first, byte_pick_second, page_latch_strobe, write_strobe_n,
        drive_strobe_n, data_in};

    pin_sync #(.WIDTH($bits(pin_group_t)), .RESET_VAL(IDLE_PINS)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(raw),
        .q(pins)
    );

    // edge finding on the synchronised pins
    assign load_rise = pins.load && !last.load;
    assign latch_rise = pins.page_latch && !last.page_latch;
    assign write_fall = !pins.write_n && last.write_n;
    assign hv_rise = pins.hv && !last.hv;
    assign hv_fall = !pins.hv && last.hv;
    assign accept = prog_mode && state == ST_IDLE;
    assign page_load = accept && latch_rise;
    assign commit = state == ST_BUSY && count == 16'h0001;
    assign nop_load = accept && load_rise && pins.action == ACT_CMD && pins.data == CMD_NOP;
    assign keep_eeprom_fuse = !fuse_high[KEEP_EE_BIT];
    assign full_addr = {addr_hi, addr_lo};
    assign fa = full_addr[FLASH_ADDR_BITS-1:0];
    assign ea = full_addr[EE_ADDR_BITS-1:0];

    // read data selection
    always_comb begin
        rd = NO_DATA;
        case (cmd)
            CMD_RD_FLASH: rd = pins.pick_first ? flash[fa][15:8] : flash[fa][7:0];
            CMD_RD_EE: rd = eeprom[ea];
            CMD_RD_SIG: rd = pins.pick_first ? CAL_BYTE : sig_byte(addr_lo[1:0]);
            CMD_RD_FUSE: begin
                unique case ({pins.pick_second, pins.pick_first})
                    2'h0: rd = fuse_low;
                    2'h1: rd = lock;
                    2'h2: rd = fuse_ext;
                    2'h3: rd = fuse_high;
                endcase
            end
            default: rd = NO_DATA;
        endcase
    end

    // command engine next values
    always_comb begin
        next_state = state;
        next_count = count;
        next_cmd = cmd;
        next_addr_lo = addr_lo;
        next_addr_hi = addr_hi;
        next_data_lo = data_lo;
        next_data_hi = data_hi;
        next_fuse_low = fuse_low;
        next_fuse_high = fuse_high;
        next_fuse_ext = fuse_ext;
        next_lock = lock;
        next_prog_mode = prog_mode;
        if (hv_fall) begin
            next_prog_mode = 1'b0;
            next_cmd = CMD_NOP;
            next_state = ST_IDLE;
            next_count = '0;
        end else if (hv_rise) begin
            next_prog_mode = {pins.page_latch, pins.action, pins.pick_first} == ENTRY_PATTERN;
        end else if (accept && load_rise) begin
            unique case (pins.action)
                ACT_ADDR: begin
                    if (pins.pick_first) begin
                        next_addr_hi = pins.data;
                    end else begin
                        next_addr_lo = pins.data;
                    end
                end
                ACT_DATA: begin
                    if (pins.pick_first) begin
                        next_data_hi = pins.data;
                    end else begin
                        next_data_lo = pins.data;
                    end
                end
                ACT_CMD: next_cmd = pins.data;
                ACT_IDLE: ;
            endcase
        end else if (accept && write_fall && is_write_cmd(cmd)) begin
            next_state = ST_BUSY;
            next_count = cmd == CMD_ERASE ? 16'(ERASE_TIME) : 16'(PROG_TIME);
        end else begin
            unique case (state)
                ST_IDLE: ;
                ST_BUSY: begin
                    next_count = count - 16'h0001;
                    if (commit) begin
                        next_state = cmd == CMD_ERASE ? ST_LOCK_CLEAR : ST_IDLE;
                        if (cmd == CMD_WR_LOCK) begin
                            next_lock = lock & data_lo;
                        end
                        if (cmd == CMD_WR_FUSE) begin
                            if (pins.pick_second) begin
                                next_fuse_ext = data_lo;
                            end else if (pins.pick_first) begin
                                next_fuse_high = data_lo;
                            end else begin
                                next_fuse_low = data_lo;
                            end
                        end
                    end
                end
                ST_LOCK_CLEAR: begin
                    next_lock = LOCK_RESET;
                    next_state = ST_IDLE;
                end
            endcase
        end
        next_progress = next_state == ST_IDLE;
        next_data_oe = next_prog_mode && !pins.drive_n;
        next_data_out = rd;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last <= IDLE_PINS;
            state <= ST_IDLE;
            count <= '0;
            cmd <= CMD_NOP;
            addr_lo <= '0;
            addr_hi <= '0;
            data_lo <= '0;
            data_hi <= '0;
            fuse_low <= FUSE_LOW_RESET;
            fuse_high <= FUSE_HIGH_RESET;
            fuse_ext <= FUSE_EXT_RESET;
            lock <= LOCK_RESET;
            prog_mode <= 1'b0;
            progress_indicator <= 1'b1;
            data_oe <= 1'b0;
            data_out <= NO_DATA;
        end else begin
            last <= pins;
            state <= next_state;
            count <= next_count;
            cmd <= next_cmd;
            addr_lo <= next_addr_lo;
            addr_hi <= next_addr_hi;
            data_lo <= next_data_lo;
            data_hi <= next_data_hi;
            fuse_low <= next_fuse_low;
            fuse_high <= next_fuse_high;
            fuse_ext <= next_fuse_ext;
            lock <= next_lock;
            prog_mode <= next_prog_mode;
            progress_indicator <= next_progress;
            data_oe <= next_data_oe;
            data_out <= next_data_out;
        end
    end

    // page buffers and memory arrays
    always_ff @(posedge clk) begin
        if (rst || nop_load) begin
            for (int i = 0; i < FLASH_PAGE; i++) begin
                flash_page[i] <= ERASED_WORD;
            end
            for (int i = 0; i < EE_PAGE; i++) begin
                ee_page[i] <= ERASED_BYTE;
            end
        end else begin
            if (page_load) begin
                if (cmd == CMD_WR_EE) begin
                    ee_page[ea[EPB-1:0]] <= data_lo;
                end else begin
                    flash_page[fa[FPB-1:0]] <= {data_hi, data_lo};
                end
            end
            if (commit) begin
                case (cmd)
                    CMD_ERASE: begin
                        for (int i = 0; i < FLASH_WORDS; i++) begin
                            flash[i] <= ERASED_WORD;
                        end
                        if (!keep_eeprom_fuse) begin
                            for (int i = 0; i < EE_BYTES; i++) begin
                                eeprom[i] <= ERASED_BYTE;
                            end
                        end
                    end
                    CMD_WR_FLASH: begin
                        for (int i = 0; i < FLASH_PAGE; i++) begin
                            flash[{fa[FLASH_ADDR_BITS-1:FPB], FPB'(i)}] <= flash_page[i];
                            flash_page[i] <= ERASED_WORD;
                        end
                    end
                    CMD_WR_EE: begin
                        for (int i = 0; i < EE_PAGE; i++) begin
                            eeprom[{ea[EE_ADDR_BITS-1:EPB], EPB'(i)}] <= ee_page[i];
                            ee_page[i] <= ERASED_BYTE;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ==== tb/prog_port_props.sv ====
// property checker for the parallel programming port
`timescale 1ns/1ns
module prog_port_props import prog_port_pkg::*; #(
    parameter int ERASE_TIME = ERASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_high_voltage,
    input wire logic strobe_action_msb,
    input wire logic strobe_action_lsb,
    input wire logic byte_pick_first,
    input wire logic page_latch_strobe,
    input wire logic drive_strobe_n,
    input wire logic data_oe,
    input wire logic progress_indicator,
    input wire logic prog_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic entry_ok;
    logic [15:0] busy_len;
    logic [15:0] next_busy_len;
    assign entry_ok = {page_latch_strobe, strobe_action_msb, strobe_action_lsb,
        byte_pick_first} == ENTRY_PATTERN;
    // counts cycles of one busy stretch
    always_comb begin
        next_busy_len = progress_indicator ? 16'h0000 : busy_len + 16'h0001;
    end
    always_ff @(posedge clk) begin
        busy_len <= rst ? 16'h0000 : next_busy_len;
    end
    sequence s_entry;
        $rose(reset_high_voltage) && entry_ok;
    endsequence
    sequence s_busy_start;
        $fell(progress_indicator);
    endsequence
    a_mode_entry: assert property (s_entry |-> ##[1:6] prog_mode)
        else $error("programming mode not entered");
    a_bad_entry: assert property ($rose(reset_high_voltage) && !entry_ok && !prog_mode
        |-> !prog_mode[*6]) else $error("mode entered with wrong pattern");
    a_mode_exit: assert property ($fell(reset_high_voltage) |-> ##[1:6] !prog_mode)
        else $error("programming mode not left");
    a_ready_out: assert property (!prog_mode[*3] |-> progress_indicator)
        else $error("busy outside programming mode");
    a_oe_mode: assert property (data_oe |-> prog_mode)
        else $error("bus driven outside programming mode");
    a_oe_release: assert property (drive_strobe_n[*5] |-> !data_oe)
        else $error("bus driven with drive strobe high");
    a_oe_drive: assert property ((prog_mode && !drive_strobe_n)[*5] |-> data_oe)
        else $error("bus not driven with drive strobe low");
    a_busy_min: assert property (s_busy_start |-> !progress_indicator[*8])
        else $error("busy stretch too short");
    a_busy_max: assert property (busy_len <= ERASE_TIME + 4)
        else $error("busy stretch too long");
endmodule

bind parallel_program_port prog_port_props #(.ERASE_TIME(ERASE_TIME)) prog_port_props_i (
    .clk(clk), .rst(rst), .reset_high_voltage(reset_high_voltage),
    .strobe_action_msb(strobe_action_msb), .strobe_action_lsb(strobe_action_lsb),
    .byte_pick_first(byte_pick_first), .page_latch_strobe(page_latch_strobe),
    .drive_strobe_n(drive_strobe_n), .data_oe(data_oe),
    .progress_indicator(progress_indicator), .prog_mode(prog_mode));

// ==== tb/prog_driver.sv ====
// programmer model driving the parallel programming pins
`timescale 1ns/1ns
module prog_driver import prog_port_pkg::*; (
    input wire logic clk,
    input wire logic data_oe,
    input wire logic [7:0] data_out,
    output pin_group_t pins,
    output logic [7:0] bus
);
    logic drv_en;
    // released bus shows the inverse of the last value
    assign bus = data_oe ? data_out : (drv_en ? pins.data : ~pins.data);
    initial begin
        pins = IDLE_PINS;
        drv_en = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // every strobe setup and pulse lasts 32 clocks
    task automatic strobe(input logic [1:0] act, input logic pf, input logic [7:0] d);
        pins.action = act;
        pins.pick_first = pf;
        pins.pick_second = 1'b0;
        pins.data = d;
        wait_n(32);
        pins.load = 1'b1;
        wait_n(32);
        pins.load = 1'b0;
        pins.action = ACT_IDLE;
        wait_n(32);
    endtask
    task automatic pulse_write(input logic pf, input logic ps);
        pins.pick_first = pf;
        pins.pick_second = ps;
        wait_n(8);
        pins.write_n = 1'b0;
        wait_n(32);
        pins.write_n = 1'b1;
    endtask
    task automatic pulse_latch();
        pins.page_latch = 1'b1;
        wait_n(32);
        pins.page_latch = 1'b0;
        wait_n(32);
    endtask
    task automatic read(input logic pf, input logic ps, output logic [7:0] rd);
        pins.pick_first = pf;
        pins.pick_second = ps;
        drv_en = 1'b0;
        pins.drive_n = 1'b0;
        wait_n(32);
        rd = bus;
        pins.drive_n = 1'b1;
        wait_n(8);
        drv_en = 1'b1;
        wait_n(8);
    endtask
    // pattern order: page latch, action msb, action lsb, first pick
    task automatic set_hv(input logic h, input logic [3:0] pat);
        {pins.page_latch, pins.action, pins.pick_first} = pat;
        pins.hv = h;
        wait_n(1250);
    endtask
endmodule

// ==== tb/parallel_program_port_bench.sv ====
// self-checking bench for the parallel programming port
`timescale 1ns/1ns
module parallel_program_port_bench import prog_port_pkg::*;;
    logic clk;
    logic rst;
    pin_group_t pins;
    logic [7:0] bus;
    logic [7:0] data_out;
    logic data_oe;
    logic progress_indicator;
    logic prog_mode;
    logic [7:0] sig_tab [4] = '{8'h5a, 8'h01, 8'h02, 8'h00};
    int err_total;
    int total_checks;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    parallel_program_port #(.PROG_TIME(48), .ERASE_TIME(200)) parallel_program_port_i (
        .clk(clk), .rst(rst), .reset_high_voltage(pins.hv), .load_strobe_pin(pins.load),
        .strobe_action_msb(pins.action[1]), .strobe_action_lsb(pins.action[0]),
        .byte_pick_first(pins.pick_first), .byte_pick_second(pins.pick_second),
        .page_latch_strobe(pins.page_latch), .write_strobe_n(pins.write_n),
        .drive_strobe_n(pins.drive_n), .data_in(bus), .data_out(data_out),
        .data_oe(data_oe), .progress_indicator(progress_indicator), .prog_mode(prog_mode));
    prog_driver prog_driver_i (.clk(clk), .data_oe(data_oe), .data_out(data_out),
        .pins(pins), .bus(bus));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic pf, input logic ps, input logic [7:0] exp);
        logic [7:0] rd;
        prog_driver_i.read(pf, ps, rd);
        check(rd, exp);
    endtask
    task automatic cmd(input logic [7:0] c);
        prog_driver_i.strobe(ACT_CMD, 1'b0, c);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (progress_indicator !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (progress_indicator !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        prog_driver_i.wait_n(32);
    endtask
    task automatic erase();
        cmd(CMD_ERASE);
        prog_driver_i.pulse_write(1'b0, 1'b0);
        check({7'h00, progress_indicator}, 8'h00);
    endtask
    initial begin
        err_total = 0;
        total_checks = 0;
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        check({5'h00, data_oe, prog_mode, progress_indicator}, 8'h01);
        prog_driver_i.set_hv(1'b1, 4'h8);
        check({7'h00, prog_mode}, 8'h00);
        prog_driver_i.set_hv(1'b0, ENTRY_PATTERN);
        prog_driver_i.set_hv(1'b1, ENTRY_PATTERN);
        prog_driver_i.wait_n(37500);
        check({7'h00, prog_mode}, 8'h01);
        cmd(CMD_RD_FUSE);
        rd_chk(1'b0, 1'b0, FUSE_LOW_RESET);
        rd_chk(1'b1, 1'b1, FUSE_HIGH_RESET);
        rd_chk(1'b0, 1'b1, FUSE_EXT_RESET);
        rd_chk(1'b1, 1'b0, LOCK_RESET);
        cmd(CMD_RD_SIG);
        for (int i = 0; i < 4; i++) begin
            prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'(i));
            rd_chk(1'b0, 1'b0, sig_tab[i]);
        end
        prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'h00);
        rd_chk(1'b1, 1'b0, 8'h80);
        erase();
        cmd(CMD_RD_FUSE);
        wait_ready();
        rd_chk(1'b0, 1'b0, NO_DATA);
        cmd(CMD_WR_FLASH);
        prog_driver_i.strobe(ACT_ADDR, 1'b1, 8'h01);
        for (int k = 0; k < 2; k++) begin
            prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'(5 + k));
            prog_driver_i.strobe(ACT_DATA, 1'b0, 8'(8'hc0 + k));
            prog_driver_i.strobe(ACT_DATA, 1'b1, 8'(8'h0a + k));
            prog_driver_i.pulse_latch();
        end
        prog_driver_i.pulse_write(1'b0, 1'b0);
        check({7'h00, progress_indicator}, 8'h00);
        wait_ready();
        cmd(CMD_NOP);
        cmd(CMD_RD_FLASH);
        for (int k = 0; k < 3; k++) begin
            prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'(5 + k));
            rd_chk(1'b0, 1'b0, k < 2 ? 8'(8'hc0 + k) : ERASED_BYTE);
            rd_chk(1'b1, 1'b0, k < 2 ? 8'(8'h0a + k) : ERASED_BYTE);
        end
        cmd(CMD_WR_EE);
        prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'h03);
        prog_driver_i.strobe(ACT_DATA, 1'b0, 8'h5a);
        prog_driver_i.pulse_latch();
        cmd(CMD_NOP);
        cmd(CMD_WR_EE);
        prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'h02);
        prog_driver_i.strobe(ACT_DATA, 1'b0, 8'ha5);
        prog_driver_i.pulse_latch();
        prog_driver_i.pulse_write(1'b0, 1'b0);
        check({7'h00, progress_indicator}, 8'h00);
        wait_ready();
        cmd(CMD_RD_EE);
        prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'h03);
        rd_chk(1'b0, 1'b0, ERASED_BYTE);
        prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'h02);
        rd_chk(1'b0, 1'b0, 8'ha5);
        cmd(CMD_WR_FUSE);
        prog_driver_i.strobe(ACT_DATA, 1'b0, 8'hd1);
        prog_driver_i.pulse_write(1'b1, 1'b0);
        wait_ready();
        prog_driver_i.strobe(ACT_DATA, 1'b0, 8'hfe);
        prog_driver_i.pulse_write(1'b0, 1'b1);
        wait_ready();
        prog_driver_i.strobe(ACT_DATA, 1'b0, 8'h6a);
        prog_driver_i.pulse_write(1'b0, 1'b0);
        wait_ready();
        cmd(CMD_WR_LOCK);
        prog_driver_i.strobe(ACT_DATA, 1'b0, 8'hfc);
        prog_driver_i.pulse_write(1'b0, 1'b0);
        wait_ready();
        cmd(CMD_RD_FUSE);
        rd_chk(1'b1, 1'b1, 8'hd1);
        rd_chk(1'b1, 1'b0, 8'hfc);
        rd_chk(1'b0, 1'b1, 8'hfe);
        rd_chk(1'b0, 1'b0, 8'h6a);
        erase();
        wait_ready();
        cmd(CMD_RD_FUSE);
        rd_chk(1'b1, 1'b1, 8'hd1);
        rd_chk(1'b1, 1'b0, LOCK_RESET);
        cmd(CMD_RD_EE);
        prog_driver_i.strobe(ACT_IDLE, 1'b0, CMD_NOP);
        rd_chk(1'b0, 1'b0, 8'ha5);
        cmd(CMD_RD_FLASH);
        prog_driver_i.strobe(ACT_ADDR, 1'b0, 8'h05);
        rd_chk(1'b0, 1'b0, ERASED_BYTE);
        prog_driver_i.set_hv(1'b0, ENTRY_PATTERN);
        check({7'h00, prog_mode}, 8'h00);
        report_and_stop();
    end
endmodule
